// ---- hw/sioa_pkg.sv ----
// constants of the servo i/o signal allocation block
//
// Summary of operation
// - pin one to four digits pick input functions
// - digits take codes 0-6, fourth adds 8/9
// - fifth pin uses lowest digit, default 0004
// - output digits pick status for three pins
// - bus select digit takes input from bus bits
// - second bus select sources fifth pin bit 24
// - inputs filtered 0 to 1000 cycles, live
package sioa_pkg;

  // ----------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_INPUT_ALLOC_FIRST   = 16'h3361;
  localparam logic [15:0] IDX_INPUT_ALLOC_SECOND  = 16'h3362;
  localparam logic [15:0] IDX_OUTPUT_ALLOC        = 16'h3363;
  localparam logic [15:0] IDX_BUS_INPUT_SEL_FIRST = 16'h3364;
  localparam logic [15:0] IDX_BUS_INPUT_SEL_SECOND = 16'h3365;
  localparam logic [15:0] IDX_INPUT_FILTER_CYCLES = 16'h3366;
  localparam logic [15:0] IDX_RESTART_CTRL        = 16'h3370;
  localparam logic [15:0] IDX_INPUT_STATUS        = 16'h3371;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_INPUT_ALLOC_FIRST   = 16'h3210;
  localparam logic [15:0] RST_INPUT_ALLOC_SECOND  = 16'h0004;
  localparam logic [15:0] RST_OUTPUT_ALLOC        = 16'h0210;
  localparam logic [15:0] RST_BUS_INPUT_SEL_FIRST = 16'h0000;
  localparam logic [15:0] RST_BUS_INPUT_SEL_SECOND = 16'h0000;
  localparam logic [15:0] RST_INPUT_FILTER_CYCLES = 16'h0001;

  // ----------------------------------------------------------------
  // field layout and codes
  // ----------------------------------------------------------------
  localparam int          DIGIT_W        = 4;
  localparam int          NUM_IN_PINS    = 5;
  localparam int          NUM_OUT_PINS   = 3;
  localparam int          NUM_IN_FUNCS   = 10;
  localparam int          NUM_OUT_FUNCS  = 12;
  localparam logic [3:0]  IN_CODE_MAX    = 4'h7;
  localparam logic [3:0]  IN_CODE_EXTERNAL_INPUT_ONE   = 4'h8;
  localparam logic [3:0]  IN_CODE_EXTERNAL_INPUT_TWO   = 4'h9;
  localparam logic [3:0]  OUT_CODE_MAX   = 4'hb;
  localparam logic [3:0]  OUT_CODE_UNUSED = 4'h9;
  localparam int          BUS_BIT_FIRST  = 16;
  localparam int          BUS_BIT_FIFTH  = 24;
  localparam int          RESTART_BIT    = 0;
  localparam int          STAT_FUNC_LSB  = 0;
  localparam int          STAT_SRC_LSB   = 10;
  localparam logic [15:0] FILTER_MAX     = 16'd1000;
  localparam int          FILT_CNT_W     = 10;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

endpackage

// ---- hw/sioa_filt_if.sv ----
// carrier between the allocation top and the input filter
`timescale 1ns/1ps
interface sioa_filt_if;
  logic [4:0]  raw;
  logic [15:0] limit;
  logic [4:0]  filtered;

  modport filt (input raw, input limit, output filtered);
  modport ctrl (output raw, output limit, input filtered);
endinterface

// ---- hw/sioa_input_filter.sv ----
// per-input change filter counted in control cycles
`timescale 1ns/1ps
module sioa_input_filter (
  input wire logic ref_clk,
  input wire logic resetn,
  sioa_filt_if.filt fio
);

  genvar g;
  generate
    for (g = 0; g < sioa_pkg::NUM_IN_PINS; g = g + 1) begin : gBit
      logic [sioa_pkg::FILT_CNT_W-1:0] cnt_r;
      logic                            level_r;

      // a change is taken once it has stood for limit plus one cycles
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          cnt_r   <= '0;
          level_r <= 1'b0;
        end else if (fio.raw[g] == level_r) begin
          cnt_r <= '0;
        end else if ({6'h00, cnt_r} >= fio.limit) begin
          level_r <= fio.raw[g];
          cnt_r   <= '0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end

      assign fio.filtered[g] = level_r;
    end
  endgenerate

endmodule

// ---- hw/sioa_top.sv ----
// servo i/o signal allocation with axi4-lite parameter registers
`timescale 1ns/1ps
module sioa_top (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [4:0]  inPin,
  input  wire logic [31:0] busDigOut,
  input  wire logic [11:0] statusFunc,
  output logic [9:0]       funcIn,
  output logic [2:0]       outPin
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] inputAllocFirst_r;
  logic [15:0] inputAllocSecond_r;
  logic [15:0] outputAlloc_r;
  logic [15:0] busInputSelFirst_r;
  logic [15:0] busInputSelSecond_r;
  logic [15:0] inputFilterCycles_r;
  logic [15:0] actInAllocFirst_r;
  logic [15:0] actInAllocSecond_r;
  logic [15:0] actOutAlloc_r;
  logic [15:0] actBusSelFirst_r;
  logic [15:0] actBusSelSecond_r;
  logic        restartPulse_r;
  logic        awreadyR;
  logic        wreadyR;
  logic        bvalidR;
  logic [1:0]  brespR;
  logic        arreadyR;
  logic        rvalidR;
  logic [1:0]  rrespR;
  logic [31:0] rdataR;
  logic        awHave_r;
  logic        wHave_r;
  logic [15:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic [15:0] wrIdx;
  logic [15:0] rdIdx;
  logic        doWrite;
  logic [15:0] wrOld;
  logic [15:0] wrNew;
  logic        wrMapped;
  logic        rdMapped;
  logic [15:0] rdValue;
  logic [4:0]  srcRaw;
  logic [9:0]  funcIn_nxt;
  logic [2:0]  outPin_nxt;
  logic [9:0]  funcIn_r;
  logic [2:0]  outPin_r;

  sioa_filt_if filtIo ();

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data may arrive in either order
  assign doWrite = awHave_r && wHave_r && !bvalidR;
  assign wrIdx   = {2'b00, awAddr_r[15:2]};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awreadyR <= 1'b0;
      awHave_r <= 1'b0;
      awAddr_r <= 16'h0000;
    end else if (s_axi_awvalid && awreadyR) begin
      awreadyR <= 1'b0;
      awHave_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_r <= 1'b0;
    end else if (!awHave_r && !bvalidR) begin
      awreadyR <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wreadyR <= 1'b0;
      wHave_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && wreadyR) begin
      wreadyR <= 1'b0;
      wHave_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_r <= 1'b0;
    end else if (!wHave_r && !bvalidR) begin
      wreadyR <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bvalidR <= 1'b0;
      brespR  <= sioa_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalidR <= 1'b1;
      brespR  <= wrMapped ? sioa_pkg::RESP_OKAY : sioa_pkg::RESP_SLVERR;
    end else if (bvalidR && s_axi_bready) begin
      bvalidR <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write decode and byte lanes
  // ----------------------------------------------------------------
  always_comb begin
    wrMapped = 1'b1;
    unique case (wrIdx)
      sioa_pkg::IDX_INPUT_ALLOC_FIRST:    wrOld = inputAllocFirst_r;
      sioa_pkg::IDX_INPUT_ALLOC_SECOND:   wrOld = inputAllocSecond_r;
      sioa_pkg::IDX_OUTPUT_ALLOC:         wrOld = outputAlloc_r;
      sioa_pkg::IDX_BUS_INPUT_SEL_FIRST:  wrOld = busInputSelFirst_r;
      sioa_pkg::IDX_BUS_INPUT_SEL_SECOND: wrOld = busInputSelSecond_r;
      sioa_pkg::IDX_INPUT_FILTER_CYCLES:  wrOld = inputFilterCycles_r;
      sioa_pkg::IDX_RESTART_CTRL:         wrOld = 16'h0000;
      sioa_pkg::IDX_INPUT_STATUS:         wrOld = 16'h0000;
      default: begin
        wrOld    = 16'h0000;
        wrMapped = 1'b0;
      end
    endcase
    wrNew[7:0]  = wStrb_r[0] ? wData_r[7:0] : wrOld[7:0];
    wrNew[15:8] = wStrb_r[1] ? wData_r[15:8] : wrOld[15:8];
  end

  // ----------------------------------------------------------------
  // stored parameter registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      inputAllocFirst_r   <= sioa_pkg::RST_INPUT_ALLOC_FIRST;
      inputAllocSecond_r  <= sioa_pkg::RST_INPUT_ALLOC_SECOND;
      outputAlloc_r       <= sioa_pkg::RST_OUTPUT_ALLOC;
      busInputSelFirst_r  <= sioa_pkg::RST_BUS_INPUT_SEL_FIRST;
      busInputSelSecond_r <= sioa_pkg::RST_BUS_INPUT_SEL_SECOND;
    end else if (doWrite) begin
      unique case (wrIdx)
        sioa_pkg::IDX_INPUT_ALLOC_FIRST:    inputAllocFirst_r   <= wrNew;
        sioa_pkg::IDX_INPUT_ALLOC_SECOND:   inputAllocSecond_r  <= wrNew;
        sioa_pkg::IDX_OUTPUT_ALLOC:         outputAlloc_r       <= wrNew;
        sioa_pkg::IDX_BUS_INPUT_SEL_FIRST:  busInputSelFirst_r  <= wrNew;
        sioa_pkg::IDX_BUS_INPUT_SEL_SECOND: busInputSelSecond_r <= wrNew;
        default: begin
        end
      endcase
    end
  end

  // filter length applies at once, clamped to its top value
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      inputFilterCycles_r <= sioa_pkg::RST_INPUT_FILTER_CYCLES;
    end else if (doWrite && wrIdx == sioa_pkg::IDX_INPUT_FILTER_CYCLES) begin
      inputFilterCycles_r <= (wrNew > sioa_pkg::FILTER_MAX) ? sioa_pkg::FILTER_MAX : wrNew;
    end
  end

  // restart strobe, routing loads one edge later
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      restartPulse_r <= 1'b0;
    end else begin
      restartPulse_r <= doWrite && (wrIdx == sioa_pkg::IDX_RESTART_CTRL) &&
                        wStrb_r[0] && wData_r[sioa_pkg::RESTART_BIT];
    end
  end

  // ----------------------------------------------------------------
  // routing in force, loaded only at restart
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      actInAllocFirst_r  <= sioa_pkg::RST_INPUT_ALLOC_FIRST;
      actInAllocSecond_r <= sioa_pkg::RST_INPUT_ALLOC_SECOND;
      actOutAlloc_r      <= sioa_pkg::RST_OUTPUT_ALLOC;
      actBusSelFirst_r   <= sioa_pkg::RST_BUS_INPUT_SEL_FIRST;
      actBusSelSecond_r  <= sioa_pkg::RST_BUS_INPUT_SEL_SECOND;
    end else if (restartPulse_r) begin
      actInAllocFirst_r  <= inputAllocFirst_r;
      actInAllocSecond_r <= inputAllocSecond_r;
      actOutAlloc_r      <= outputAlloc_r;
      actBusSelFirst_r   <= busInputSelFirst_r;
      actBusSelSecond_r  <= busInputSelSecond_r;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // read data captured at the address handshake
  assign rdIdx = {2'b00, s_axi_araddr[15:2]};

  always_comb begin
    rdMapped = 1'b1;
    unique case (rdIdx)
      sioa_pkg::IDX_INPUT_ALLOC_FIRST:    rdValue = inputAllocFirst_r;
      sioa_pkg::IDX_INPUT_ALLOC_SECOND:   rdValue = inputAllocSecond_r;
      sioa_pkg::IDX_OUTPUT_ALLOC:         rdValue = outputAlloc_r;
      sioa_pkg::IDX_BUS_INPUT_SEL_FIRST:  rdValue = busInputSelFirst_r;
      sioa_pkg::IDX_BUS_INPUT_SEL_SECOND: rdValue = busInputSelSecond_r;
      sioa_pkg::IDX_INPUT_FILTER_CYCLES:  rdValue = inputFilterCycles_r;
      sioa_pkg::IDX_RESTART_CTRL:         rdValue = 16'h0000;
      sioa_pkg::IDX_INPUT_STATUS:         rdValue = {1'b0, filtIo.filtered, funcIn_r};
      default: begin
        rdValue  = 16'h0000;
        rdMapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arreadyR <= 1'b0;
      rvalidR  <= 1'b0;
      rrespR   <= sioa_pkg::RESP_OKAY;
      rdataR   <= 32'h0000_0000;
    end else if (s_axi_arvalid && arreadyR) begin
      arreadyR <= 1'b0;
      rvalidR  <= 1'b1;
      rdataR   <= {16'h0000, rdValue};
      rrespR   <= rdMapped ? sioa_pkg::RESP_OKAY : sioa_pkg::RESP_SLVERR;
    end else if (rvalidR && s_axi_rready) begin
      rvalidR <= 1'b0;
    end else if (!rvalidR) begin
      arreadyR <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // input source select, pin or fieldbus bit
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      srcRaw[p] = actBusSelFirst_r[p*sioa_pkg::DIGIT_W] ?
                  busDigOut[sioa_pkg::BUS_BIT_FIRST + p] : inPin[p];
    end
    srcRaw[4] = actBusSelSecond_r[0] ? busDigOut[sioa_pkg::BUS_BIT_FIFTH] : inPin[4];
  end

  assign filtIo.raw   = srcRaw;
  assign filtIo.limit = inputFilterCycles_r;

  sioa_input_filter uFilter (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .fio     (filtIo.filt)
  );

  // ----------------------------------------------------------------
  // input function allocation
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] code;
    code       = 4'h0;
    funcIn_nxt = 10'h000;
    for (int p = 0; p < 4; p++) begin
      code = actInAllocFirst_r[p*sioa_pkg::DIGIT_W +: sioa_pkg::DIGIT_W];
      if (code < sioa_pkg::IN_CODE_MAX) begin
        funcIn_nxt[code] = funcIn_nxt[code] | filtIo.filtered[p];
      end else if (p == 3 && (code == sioa_pkg::IN_CODE_EXTERNAL_INPUT_ONE ||
                              code == sioa_pkg::IN_CODE_EXTERNAL_INPUT_TWO)) begin
        funcIn_nxt[code] = funcIn_nxt[code] | filtIo.filtered[p];
      end
    end
    code = actInAllocSecond_r[3:0];
    if (code < sioa_pkg::IN_CODE_MAX) begin
      funcIn_nxt[code] = funcIn_nxt[code] | filtIo.filtered[4];
    end
  end

  // ----------------------------------------------------------------
  // output function allocation
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] code;
    code       = 4'h0;
    outPin_nxt = 3'b000;
    for (int q = 0; q < sioa_pkg::NUM_OUT_PINS; q++) begin
      code = actOutAlloc_r[q*sioa_pkg::DIGIT_W +: sioa_pkg::DIGIT_W];
      if (code <= sioa_pkg::OUT_CODE_MAX && code != sioa_pkg::OUT_CODE_UNUSED) begin
        outPin_nxt[q] = statusFunc[code];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      funcIn_r <= 10'h000;
    end else begin
      funcIn_r <= funcIn_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      outPin_r <= 3'b000;
    end else begin
      outPin_r <= outPin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign funcIn        = funcIn_r;
  assign outPin        = outPin_r;
  assign s_axi_awready = awreadyR;
  assign s_axi_wready  = wreadyR;
  assign s_axi_bvalid  = bvalidR;
  assign s_axi_bresp   = brespR;
  assign s_axi_arready = arreadyR;
  assign s_axi_rvalid  = rvalidR;
  assign s_axi_rresp   = rrespR;
  assign s_axi_rdata   = rdataR;

endmodule

// ---- verif/sioa_pins_model.sv ----
// connector switches and indicator lamps
`timescale 1ns/1ps
module sioa_pins_model (
  input  wire logic       ref_clk,
  input  wire logic [4:0] swLevel,
  input  wire logic [2:0] outPin,
  output logic [4:0]      inPin,
  output logic [2:0]      lamp
);
  // switches drive the pins as steady levels
  assign inPin = swLevel;
  always_ff @(posedge ref_clk) lamp <= outPin;
endmodule

// ---- verif/sioa_top_properties.sv ----
// checker of bus handshakes and pin routing
`timescale 1ns/1ps
module sioa_top_properties (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [4:0]  inPin,
  input wire logic [31:0] busDigOut,
  input wire logic [11:0] statusFunc,
  input wire logic [9:0]  funcIn,
  input wire logic [2:0]  outPin
);
  logic [10:0] quietCnt_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // cycles with every source low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      quietCnt_r <= 11'h000;
    end else if (inPin != 5'h00 || busDigOut != 32'h0000_0000) begin
      quietCnt_r <= 11'h000;
    end else if (quietCnt_r != 11'h3f2) begin
      quietCnt_r <= quietCnt_r + 11'h001;
    end
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read busy");
  a_code_seven: assert property (funcIn[7] == 1'b0) else $error("code seven driven");
  a_out_quiet: assert property ($past(statusFunc) == 12'h000 |-> outPin == 3'b000)
    else $error("output without status");
  a_func_quiet: assert property (quietCnt_r >= 11'h3eb |-> funcIn == 10'h000)
    else $error("function without source");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == sioa_pkg::RESP_SLVERR);
  c_ext_two: cover property (funcIn[9]);
  c_quiet: cover property (quietCnt_r == 11'h3f2);
endmodule

bind sioa_top sioa_top_properties u_props (.ref_clk(ref_clk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .inPin(inPin), .busDigOut(busDigOut), .statusFunc(statusFunc), .funcIn(funcIn),
  .outPin(outPin));

// ---- verif/tb_servo_io_signal_allocation.sv ----
// self-checking bench of the servo i/o allocation block
`timescale 1ns/1ps
module tb_servo_io_signal_allocation;
  logic        ref_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, busDigOut;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  swLevel, inPin;
  logic [11:0] statusFunc;
  logic [9:0]  funcIn;
  logic [2:0]  outPin;
  logic [15:0] live [5];
  integer      seed = 46;
  int          mismatches = 0, compares = 0, cyc = 0, nf = 1;
  localparam logic [15:0] FILT = sioa_pkg::IDX_INPUT_FILTER_CYCLES;
  // columns: alloc first, alloc second, output alloc, bus select first, second
  localparam logic [15:0] CFG [4][5] = '{
    '{16'h3210, 16'h0004, 16'h0210, 16'h0000, 16'h0000},
    '{16'h9654, 16'h0007, 16'h0543, 16'h1111, 16'h0001},
    '{16'h8880, 16'h0002, 16'h0876, 16'h0101, 16'h0000},
    '{16'h7123, 16'h0006, 16'h0b9a, 16'h0010, 16'h0001}};
  localparam logic [15:0] IDX [5] = '{sioa_pkg::IDX_INPUT_ALLOC_FIRST,
    sioa_pkg::IDX_INPUT_ALLOC_SECOND, sioa_pkg::IDX_OUTPUT_ALLOC,
    sioa_pkg::IDX_BUS_INPUT_SEL_FIRST, sioa_pkg::IDX_BUS_INPUT_SEL_SECOND};

  sioa_top dut (.ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .inPin(inPin), .busDigOut(busDigOut),
    .statusFunc(statusFunc), .funcIn(funcIn), .outPin(outPin));
  sioa_pins_model pins (.ref_clk(ref_clk), .swLevel(swLevel), .outPin(outPin),
    .inPin(inPin), .lamp());

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [9:0] efin(logic [4:0] p, logic [31:0] b);
    logic [9:0] f;
    logic       s;
    logic [3:0] c;
    f = 10'h000;
    for (int i = 0; i < 5; i++) begin
      s = (i < 4) ? (live[3][4*i] ? b[16+i] : p[i]) : (live[4][0] ? b[24] : p[4]);
      c = (i < 4) ? live[0][4*i+:4] : live[1][3:0];
      if (c < 4'h7 || (i == 3 && (c == 4'h8 || c == 4'h9))) f[c] = f[c] | s;
    end
    return f;
  endfunction

  function automatic logic [4:0] esrc(logic [4:0] p, logic [31:0] b);
    logic [4:0] s;
    for (int i = 0; i < 4; i++) s[i] = live[3][4*i] ? b[16+i] : p[i];
    s[4] = live[4][0] ? b[24] : p[4];
    return s;
  endfunction

  function automatic logic [2:0] eout(logic [11:0] sf);
    logic [3:0] c;
    logic [2:0] o;
    for (int q = 0; q < 3; q++) begin
      c = live[2][4*q+:4];
      o[q] = (c <= 4'hb && c != 4'h9) ? sf[c] : 1'b0;
    end
    return o;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [15:0] idx, input logic [15:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= {idx[13:0], 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= {idx[13:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge ref_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rnd(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      swLevel <= 5'($random(seed));
      busDigOut <= $random(seed);
      statusFunc <= 12'($random(seed));
      repeat (nf + 3) @(posedge ref_clk);
      chk("funcIn", 32'(efin(swLevel, busDigOut)), 32'(funcIn));
      chk("outPin", 32'(eout(statusFunc)), 32'(outPin));
    end
  endtask

  task automatic meas;
    int d;
    d = 0;
    do begin
      @(posedge ref_clk);
      d++;
    end while (funcIn[0] !== 1'b1 && d < 40);
    chk("filter delay", 32'(nf + 3), 32'(d));
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 16'h0000;
    s_axi_araddr = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    busDigOut = 32'h0000_0000;
    swLevel = 5'h00;
    statusFunc = 12'h000;
    live = CFG[0];
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) begin
      axr(IDX[i], d, r);
      chk("reset value", {16'h0000, CFG[0][i]}, d);
    end
    axr(FILT, d, r);
    chk("filter reset", 32'h0000_0001, d);
    axr(16'h3300, d, r);
    chk("unmapped read", {30'h0, sioa_pkg::RESP_SLVERR}, {30'h0, r});
    axw(16'h3300, 16'h1234, r);
    chk("unmapped write", {30'h0, sioa_pkg::RESP_SLVERR}, {30'h0, r});
    rnd(10);
    $display("reset and default routing done");
    axw(FILT, 16'h0005, r);
    nf = 5;
    swLevel <= 5'h00;
    busDigOut <= 32'h0000_0000;
    repeat (12) @(posedge ref_clk);
    swLevel <= 5'h01;
    repeat (nf) @(posedge ref_clk);
    swLevel <= 5'h00;
    repeat (16) begin
      @(posedge ref_clk);
      chk("short pulse", 32'h0000_0000, 32'(funcIn[0]));
    end
    swLevel <= 5'h01;
    meas;
    @(posedge ref_clk);
    swLevel <= 5'h00;
    axw(FILT, 16'h0000, r);
    nf = 0;
    repeat (4) @(posedge ref_clk);
    swLevel <= 5'h01;
    meas;
    axw(FILT, 16'h07d0, r);
    swLevel <= 5'h00;
    repeat (1001) @(posedge ref_clk);
    chk("long filter held", 32'h0000_0001, 32'(funcIn[0]));
    repeat (2) @(posedge ref_clk);
    chk("long filter done", 32'h0000_0000, 32'(funcIn[0]));
    repeat (8) @(posedge ref_clk);
    axr(FILT, d, r);
    chk("filter ceiling", 32'h0000_03e8, d);
    axw(FILT, 16'h0000, r);
    $display("filter done");
    for (int k = 1; k < 4; k++) begin
      for (int i = 0; i < 5; i++) axw(IDX[i], CFG[k][i], r);
      rnd(4);
      for (int i = 0; i < 5; i++) begin
        axr(IDX[i], d, r);
        chk("stored value", {16'h0000, CFG[k][i]}, d);
      end
      axw(sioa_pkg::IDX_RESTART_CTRL, 16'h0001, r);
      live = CFG[k];
      rnd(12);
      axr(sioa_pkg::IDX_INPUT_STATUS, d, r);
      chk("input status", {17'h0, esrc(swLevel, busDigOut), efin(swLevel, busDigOut)}, d);
      $display("config %0d done", k);
    end
    end_sim;
  end
endmodule
